// [design/atep_defines.vh]
`ifndef ATEP_DEFINES_VH
`define ATEP_DEFINES_VH

// Register byte offsets on the Avalon-MM slave.
`define ATEP_OFS_SELECT    4'h0
`define ATEP_OFS_PRESCALE  4'h4
`define ATEP_OFS_FLAG      4'h8
`define ATEP_OFS_CLEAR     4'hc

// Select register fields.
`define ATEP_SEL_B_EN      15
`define ATEP_SEL_B_SRC_HI  14
`define ATEP_SEL_B_SRC_LO  12
`define ATEP_SEL_A_EN      11
`define ATEP_SEL_A_SRC_HI  10
`define ATEP_SEL_A_SRC_LO  8

// Prescale register fields.
`define ATEP_PS_B_CNT_HI   15
`define ATEP_PS_B_CNT_LO   14
`define ATEP_PS_B_PRD_HI   13
`define ATEP_PS_B_PRD_LO   12
`define ATEP_PS_A_CNT_HI   11
`define ATEP_PS_A_CNT_LO   10
`define ATEP_PS_A_PRD_HI   9
`define ATEP_PS_A_PRD_LO   8

// Flag and clear register bits.
`define ATEP_FLG_A         2
`define ATEP_FLG_B         3

// Source selection codes.
`define ATEP_SRC_ZERO      3'h1
`define ATEP_SRC_PERIOD    3'h2
`define ATEP_SRC_CA_UP     3'h4
`define ATEP_SRC_CA_DN     3'h5
`define ATEP_SRC_CB_UP     3'h6
`define ATEP_SRC_CB_DN     3'h7

// Reset values.
`define ATEP_RST_SELECT    16'h0000
`define ATEP_RST_PRESCALE  16'h0000

`endif

// [design/atep_channel.v]
`include "atep_defines.vh"

module atep_channel #(
  parameter CW = 2
) (
  input  wire          sys_clk,
  input  wire          sys_rst,
  input  wire          enable,
  input  wire [2:0]    sourceSelect,
  input  wire [CW-1:0] eventPeriod,
  input  wire          evZero,
  input  wire          evPeriod,
  input  wire          evCmpAUp,
  input  wire          evCmpADn,
  input  wire          evCmpBUp,
  input  wire          evCmpBDn,
  output wire [CW-1:0] eventCount,
  output reg           triggerPulse
);

  reg  [CW-1:0] count_r;
  reg  [CW-1:0] count_nxt;
  reg           hit;
  reg           fire;

  assign eventCount = count_r;

  // ---------------------------------------------------------------
  // Event selection
  // ---------------------------------------------------------------
  always @* begin
    case (sourceSelect)
      `ATEP_SRC_ZERO:   hit = evZero;
      `ATEP_SRC_PERIOD: hit = evPeriod;
      `ATEP_SRC_CA_UP:  hit = evCmpAUp;
      `ATEP_SRC_CA_DN:  hit = evCmpADn;
      `ATEP_SRC_CB_UP:  hit = evCmpBUp;
      `ATEP_SRC_CB_DN:  hit = evCmpBDn;
      default:          hit = 1'b0; // R14
    endcase
  end

  // ---------------------------------------------------------------
  // Counter and pulse
  // ---------------------------------------------------------------
  // The pending status flag is not an input here on purpose: a set flag
  // never holds back a pulse. With the pulse disabled the counter parks at
  // the period so events are not lost beyond it.
  always @* begin
    count_nxt = count_r;
    fire      = 1'b0;
    // The sum carries one extra bit, so a full count cannot wrap past a
    // period that software has lowered below it.
    if (eventPeriod == {CW{1'b0}}) begin // R4 R11
      count_nxt = {CW{1'b0}};
    end else if (hit) begin
      if ({1'b0, count_r} + {{CW{1'b0}}, 1'b1} >= {1'b0, eventPeriod}) begin // R5 R11
        if (enable) begin // R6 R12
          fire      = 1'b1; // R7 R12
          count_nxt = {CW{1'b0}}; // R8 R13
        end else begin
          count_nxt = eventPeriod;
        end
      end else begin
        count_nxt = count_r + 1'b1; // R1 R9
      end
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      count_r      <= {CW{1'b0}};
      triggerPulse <= 1'b0;
    end else begin
      count_r      <= count_nxt;
      triggerPulse <= fire; // R15
    end
  end

endmodule

// [design/atep_trigger_prescaler.v]
// How it works
// [R1] Channel B counts its selected events, two bits.
// [R2] B count at bits 15-14, read-only, reset zero.
// [R3] B period field at bits 13-12, read/write.
// [R4] B period zero disables counter and pulse.
// [R5] B pulse when count reaches period value.
// [R6] B pulse only while B enable set.
// [R7] Pending B flag never blocks B pulse.
// [R8] B count cleared whenever B pulse fires.
// [R9] Channel A counts its selected events, two bits.
// [R10] A count at bits 11-10, read-only, reset zero.
// [R11] A period at bits 9-8, zero disables.
// [R12] A pulse needs enable, ignores pending flag.
// [R13] A count cleared whenever A pulse fires.
// [R14] Three-bit source code picks counted event.
// [R15] Each trigger is one-cycle pulse, next cycle.
// [R16] Prescale bits 7-0 read zero, ignore writes.
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`include "atep_defines.vh"

module atep_trigger_prescaler #(
  parameter CW = 2
) (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output reg  [1:0]  avs_response,
  input  wire        evZero,
  input  wire        evPeriod,
  input  wire        evCmpAUp,
  input  wire        evCmpADn,
  input  wire        evCmpBUp,
  input  wire        evCmpBDn,
  output wire        conv_a_trigger_pulse,
  output wire        conv_b_trigger_pulse
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg  [15:0]   select_r;
  reg  [1:0]    convAPeriod_r;
  reg  [1:0]    convBPeriod_r;
  reg           flagA_r;
  reg           flagB_r;
  reg           ack_r;
  wire [CW-1:0] convACount;
  wire [CW-1:0] convBCount;
  wire [15:0]   prescaleView;
  wire          acc;
  wire          wrSel;
  wire          wrPs;
  wire          wrClr;
  reg  [31:0]   rdMux;
  reg           mapped;

  wire       conv_a_trigger_enable = select_r[`ATEP_SEL_A_EN];
  wire       conv_b_trigger_enable = select_r[`ATEP_SEL_B_EN];
  wire [2:0] conv_a_source_select  = select_r[`ATEP_SEL_A_SRC_HI:`ATEP_SEL_A_SRC_LO];
  wire [2:0] conv_b_source_select  = select_r[`ATEP_SEL_B_SRC_HI:`ATEP_SEL_B_SRC_LO];

  // Count fields sit above the period fields; low byte is always zero.
  assign prescaleView = {convBCount, convBPeriod_r, convACount, convAPeriod_r,
                         8'h00}; // R2 R10 R16

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------
  // One wait cycle per access: the answer is registered, so read data come
  // from flip-flops and every access completes in exactly two cycles.
  assign acc             = (avs_read | avs_write) & ~ack_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wrSel = avs_write & ack_r & (avs_address == `ATEP_OFS_SELECT);
  assign wrPs  = avs_write & ack_r & (avs_address == `ATEP_OFS_PRESCALE);
  assign wrClr = avs_write & ack_r & (avs_address == `ATEP_OFS_CLEAR);

  always @* begin
    rdMux  = 32'h0000_0000;
    mapped = 1'b1;
    case (avs_address)
      `ATEP_OFS_SELECT:   rdMux = {16'h0000, select_r[15:8], 8'h00};
      `ATEP_OFS_PRESCALE: rdMux = {16'h0000, prescaleView};
      `ATEP_OFS_FLAG:     rdMux = {28'h0000000, flagB_r, flagA_r, 2'b00};
      `ATEP_OFS_CLEAR:    rdMux = 32'h0000_0000;
      default:            mapped = 1'b0;
    endcase
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_r        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end else begin
      ack_r <= acc;
      if (acc) begin
        avs_readdata <= avs_read ? rdMux : 32'h0000_0000;
        avs_response <= mapped ? 2'b00 : 2'b11;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      select_r      <= `ATEP_RST_SELECT;
      convAPeriod_r <= 2'b00;
      convBPeriod_r <= 2'b00;
    end else begin
      if (wrSel && avs_byteenable[1]) begin
        select_r[15:8] <= avs_writedata[15:8];
      end
      if (wrPs && avs_byteenable[1]) begin
        convBPeriod_r <= avs_writedata[`ATEP_PS_B_PRD_HI:`ATEP_PS_B_PRD_LO]; // R3
        convAPeriod_r <= avs_writedata[`ATEP_PS_A_PRD_HI:`ATEP_PS_A_PRD_LO]; // R11
      end
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // A pulse in the same cycle as a software clear keeps the flag set.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      flagA_r <= 1'b0;
      flagB_r <= 1'b0;
    end else begin
      flagA_r <= conv_a_trigger_pulse |
                 (flagA_r & ~(wrClr & avs_byteenable[0] & avs_writedata[`ATEP_FLG_A]));
      flagB_r <= conv_b_trigger_pulse |
                 (flagB_r & ~(wrClr & avs_byteenable[0] & avs_writedata[`ATEP_FLG_B]));
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  // R9 R10 R11 R12 R13 R14 R15
  atep_channel #(
    .CW (CW)
  ) uChanA (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .enable       (conv_a_trigger_enable),
    .sourceSelect (conv_a_source_select),
    .eventPeriod  (convAPeriod_r[CW-1:0]),
    .evZero       (evZero),
    .evPeriod     (evPeriod),
    .evCmpAUp     (evCmpAUp),
    .evCmpADn     (evCmpADn),
    .evCmpBUp     (evCmpBUp),
    .evCmpBDn     (evCmpBDn),
    .eventCount   (convACount),
    .triggerPulse (conv_a_trigger_pulse)
  );

  // R1 R2 R4 R5 R6 R7 R8 R14 R15
  atep_channel #(
    .CW (CW)
  ) uChanB (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .enable       (conv_b_trigger_enable),
    .sourceSelect (conv_b_source_select),
    .eventPeriod  (convBPeriod_r[CW-1:0]),
    .evZero       (evZero),
    .evPeriod     (evPeriod),
    .evCmpAUp     (evCmpAUp),
    .evCmpADn     (evCmpADn),
    .evCmpBUp     (evCmpBUp),
    .evCmpBDn     (evCmpBDn),
    .eventCount   (convBCount),
    .triggerPulse (conv_b_trigger_pulse)
  );

endmodule

// [verification/atep_adc_model.sv]
// ----------------------------------------
// Converter start input
// ----------------------------------------
module atep_adc_model (
  input  logic       sys_clk,
  input  logic       sys_rst,
  input  logic       conv_a_trigger_pulse,
  input  logic       conv_b_trigger_pulse,
  output logic [7:0] convACount,
  output logic [7:0] convBCount
);
  timeunit 1ns;
  timeprecision 1ps;
  // One conversion starts per sampled high cycle, so a stuck trigger shows as extra starts.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      convACount <= 8'h0;
      convBCount <= 8'h0;
    end else begin
      convACount <= convACount + {7'h0, conv_a_trigger_pulse};
      convBCount <= convBCount + {7'h0, conv_b_trigger_pulse};
    end
  end
endmodule

// [verification/atep_checker.sv]
module atep_checker #(
  parameter CW = 2
) (
  input logic        sys_clk,
  input logic        sys_rst,
  input logic [3:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0]  avs_byteenable,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic [1:0]  avs_response,
  input logic        evZero,
  input logic        evPeriod,
  input logic        evCmpAUp,
  input logic        evCmpADn,
  input logic        evCmpBUp,
  input logic        evCmpBDn,
  input logic        conv_a_trigger_pulse,
  input logic        conv_b_trigger_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req;
  logic rdDone;
  logic evAny;
  assign req = avs_read | avs_write;
  assign rdDone = avs_read & ~avs_waitrequest;
  assign evAny = evZero | evPeriod | evCmpAUp | evCmpADn | evCmpBUp | evCmpBDn;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence oneWait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  wait_one_a: assert property (req && !$past(req) |-> oneWait)
    else $error("bus answer not after one wait cycle");
  idle_wait_a: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without request");
  rdata_hold_a: assert property (!req |-> $stable(avs_readdata) && $stable(avs_response))
    else $error("bus answer changed while idle");
  unmapped_resp_a: assert property (rdDone && avs_address[1:0] != 2'h0 |-> avs_response == 2'h3)
    else $error("unmapped read not refused");
  mapped_resp_a: assert property (rdDone && avs_address[1:0] == 2'h0 |-> avs_response == 2'h0)
    else $error("mapped read refused");
  rsvd_zero_a: assert property (rdDone && avs_address == 4'h4 |-> avs_readdata[7:0] == 8'h0)
    else $error("prescale low byte not zero");
  a_cause_a: assert property (conv_a_trigger_pulse |-> $past(evAny))
    else $error("trigger A without event");
  b_cause_a: assert property (conv_b_trigger_pulse |-> $past(evAny))
    else $error("trigger B without event");
  rst_quiet_a: assert property ($past(sys_rst) |-> !conv_a_trigger_pulse && !conv_b_trigger_pulse)
    else $error("trigger right after reset");
endmodule

bind atep_trigger_prescaler atep_checker #(.CW(CW)) atep_checker_i (.*);

// [verification/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic [5:0]  ev = 6'h0;
  wire         evZero, evPeriod, evCmpAUp, evCmpADn, evCmpBUp, evCmpBDn;
  logic        conv_a_trigger_pulse;
  logic        conv_b_trigger_pulse;
  logic [7:0]  convACount;
  logic [7:0]  convBCount;
  logic [31:0] rd;
  logic [2:0]  src [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [7:0]  nP = 8'h0;
  int          errorCnt = 0;
  int          checkCount = 0;
  int          cycles = 0;
  assign {evCmpBDn, evCmpBUp, evCmpADn, evCmpAUp, evPeriod, evZero} = ev;
  atep_trigger_prescaler atep_trigger_prescaler_i (.*);
  atep_adc_model atep_adc_model_i (.*);
  initial forever #2 sys_clk = ~sys_clk;

  task automatic completeRun();
    if (errorCnt == 0 && checkCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // One idle cycle follows every access, so no request ever meets a stale acknowledge.
  task automatic access(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic fire(input logic [5:0] m);
    ev <= m;
    @(posedge sys_clk);
    ev <= 6'h0;
    repeat (2) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errorCnt++;
      completeRun();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    access(1'b0, 4'h4, 32'h0);
    chk("prescale reset", 32'h0, rd);
    access(1'b1, 4'h0, 32'h9900);
    fire(6'h01);
    fire(6'h01);
    access(1'b0, 4'h4, 32'h0);
    chk("idle count", 32'h0, rd);
    chk("idle starts", 32'h0, {16'h0, convACount, convBCount});
    access(1'b1, 4'h4, 32'hffff);
    access(1'b0, 4'h4, 32'h0);
    chk("prescale rw", 32'h3300, rd);
    access(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h3, {30'h0, avs_response});
    for (logic [1:0] p = 1; p != 2'h0; p++) begin
      for (int i = 0; i < 6; i++) begin
        access(1'b1, 4'h0, {16'h0, 1'b1, src[i], 1'b1, src[i], 8'h0});
        access(1'b1, 4'h4, {18'h0, p, 2'h0, p, 8'h0});
        fire(6'h3f ^ (6'h1 << i));
        for (logic [1:0] k = 1; k < p; k++) begin
          fire(6'h1 << i);
          access(1'b0, 4'h4, 32'h0);
          chk("count", {16'h0, k, p, k, p, 8'h0}, rd);
        end
        fire(6'h1 << i);
        nP++;
        access(1'b0, 4'h4, 32'h0);
        chk("count clear", {18'h0, p, 2'h0, p, 8'h0}, rd);
        chk("starts", {16'h0, nP, nP}, {16'h0, convACount, convBCount});
      end
    end
    access(1'b0, 4'h8, 32'h0);
    chk("flags", 32'hc, rd);
    access(1'b1, 4'hc, 32'hc);
    access(1'b0, 4'h8, 32'h0);
    chk("flags cleared", 32'h0, rd);
    access(1'b1, 4'h0, 32'h1100);
    access(1'b1, 4'h4, 32'h1100);
    fire(6'h01);
    access(1'b0, 4'h4, 32'h0);
    chk("parked count", 32'h5500, rd);
    chk("no start", {16'h0, nP, nP}, {16'h0, convACount, convBCount});
    access(1'b1, 4'h4, 32'h3300);
    fire(6'h01);
    fire(6'h01);
    access(1'b0, 4'h4, 32'h0);
    chk("parked at three", 32'hff00, rd);
    access(1'b1, 4'h0, 32'h9900);
    access(1'b1, 4'h4, 32'h1100);
    fire(6'h01);
    nP++;
    access(1'b0, 4'h4, 32'h0);
    chk("lowered period", 32'h1100, rd);
    chk("lowered starts", {16'h0, nP, nP}, {16'h0, convACount, convBCount});
    access(1'b1, 4'h0, 32'hb800);
    fire(6'h3f);
    access(1'b0, 4'h4, 32'h0);
    chk("reserved count", 32'h1100, rd);
    chk("reserved starts", {16'h0, nP, nP}, {16'h0, convACount, convBCount});
    completeRun();
  end
endmodule
